/* File: nfs_pkg.sv */
package nfs_pkg;

  // Data path widths
  localparam int FREQ_W = 48;
  localparam int ROM_ADDR_W = 24;
  localparam int AMP_W = 16;
  localparam int DAC_W = 14;
  localparam int DATA_W = 8;
  localparam int SEL_W = 4;
  localparam int QUAD_W = 2;

  // Host port map
  localparam int REG_COUNT = 13;
  localparam int WORD_BYTES = 6;
  localparam int CTRL_IDX = 12;
  localparam logic [SEL_W-1:0] CF_BASE_ADDR = 4'h0;
  localparam logic [SEL_W-1:0] OF_BASE_ADDR = 4'h6;
  localparam logic [SEL_W-1:0] CTRL_ADDR = 4'hd;
  localparam int CTRL_CF_EN_BIT = 4;
  localparam int CTRL_ACC_FB_BIT = 5;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h30;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;

  // Latencies in synthesis clocks
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WRITE_LAT_CLKS = 11;
  localparam int UPDATE_LAT_CLKS = 14;
  localparam int RESET_LAT_CLKS = 11;
  localparam int SYNC_STAGES = 2;
  localparam int FREQ_TO_OUT_CLKS = 4;
  localparam int WR_FRONT_CLKS = 6;
  localparam int UPD_DLY = UPDATE_LAT_CLKS - FREQ_TO_OUT_CLKS - SYNC_STAGES - 2;
  localparam int OFS_DLY = UPDATE_LAT_CLKS - FREQ_TO_OUT_CLKS - SYNC_STAGES - 1;

  // Sine evaluation constants
  localparam int HALF_W = ROM_ADDR_W - 1;
  localparam logic [ROM_ADDR_W-1:0] HALF_TURN = 24'h800000;
  localparam int SQ_SHIFT = 29;
  localparam int UNIT_SHIFT = 15;
  localparam logic [15:0] CORR_NUM = 16'h01cd;
  localparam int CORR_SHIFT = 11;
  localparam logic [AMP_W-1:0] AMP_PEAK = 16'h7fff;
  localparam logic [AMP_W:0] ROUND_HALF = 17'h00002;
  localparam int ROUND_DROP = AMP_W - DAC_W;
  localparam logic [DAC_W-1:0] DAC_MAX = 14'h1fff;

  typedef struct packed {
    logic strobe;
    logic write_en_n;
    logic [SEL_W-1:0] register_select_bus;
    logic [DATA_W-1:0] write_data_bus;
  } nfs_wr_port_t;

  typedef struct packed {
    logic update_n;
    logic offset_word_enable;
    logic phase_sel_hi;
    logic phase_sel_lo;
  } nfs_ctrl_pins_t;

endpackage : nfs_pkg

/* File: nfs_sine_rom.sv */
`timescale 1ns/1ps
`default_nettype none

module nfs_sine_rom
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Phase in, amplitude out
  input wire logic [nfs_pkg::ROM_ADDR_W-1:0] phase_addr,
  output logic signed [nfs_pkg::AMP_W-1:0] amp
);
  import nfs_pkg::*;

  wire logic half_sel;
  wire logic [HALF_W-1:0] half_pos;
  wire logic [ROM_ADDR_W-1:0] half_rest;
  wire logic [47:0] para_prod;
  wire logic [16:0] para_s;
  wire logic [33:0] para_sq;
  wire logic [16:0] para_s2;
  wire logic [16:0] para_d;
  wire logic [32:0] corr_prod;
  wire logic [16:0] corr;
  wire logic [16:0] mag_raw;
  wire logic [AMP_W-1:0] mag;
  wire logic [AMP_W-1:0] amp_next;

  // Top address bit selects the second half cycle
  assign half_sel = phase_addr[ROM_ADDR_W-1];
  assign half_pos = phase_addr[HALF_W-1:0];
  assign half_rest = HALF_TURN - {1'b0, half_pos};
  // One full period over the 24-bit address
  assign para_prod = {24'h000000, 1'b0, half_pos} * {24'h000000, half_rest};
  assign para_s = para_prod[SQ_SHIFT+16:SQ_SHIFT];
  assign para_sq = para_s * para_s;
  assign para_s2 = para_sq[UNIT_SHIFT+16:UNIT_SHIFT];
  assign para_d = para_s - para_s2;
  assign corr_prod = {16'h0000, para_d} * {17'h00000, CORR_NUM};
  assign corr = corr_prod[CORR_SHIFT+16:CORR_SHIFT];
  assign mag_raw = para_s - corr;
  // Quarter-turn peak reaches 2^15, so clip it to the positive peak
  assign mag = (mag_raw > {1'b0, AMP_PEAK}) ? AMP_PEAK : mag_raw[AMP_W-1:0];
  assign amp_next = half_sel ? (~mag + 16'h0001) : mag;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      amp <= '0;
    else
      amp <= amp_next;
  end

endmodule : nfs_sine_rom

`default_nettype wire

/* File: nfs_core.sv */
`timescale 1ns/1ps
`default_nettype none

module nfs_core
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Host write port
  input wire nfs_pkg::nfs_wr_port_t wr_port,
  // Modulation and update pins
  input wire nfs_pkg::nfs_ctrl_pins_t ctrl_pins,
  // Converter side
  output logic [nfs_pkg::DAC_W-1:0] dac_code,
  output logic signed [nfs_pkg::AMP_W-1:0] sine_amp
);
  import nfs_pkg::*;

  // Write strobe synchronizer
  nfs_wr_port_t wr_s1_reg;
  nfs_wr_port_t wr_s2_reg;
  logic wr_s3_reg;
  logic wr_dly_reg;
  logic wr_go_reg;
  logic [SEL_W-1:0] wr_sel_reg;
  logic [DATA_W-1:0] wr_data_reg;
  wire logic wr_edge;

  // Control pin synchronizer and delay lines
  nfs_ctrl_pins_t pins_s1_reg;
  nfs_ctrl_pins_t pins_s2_reg;
  logic [UPD_DLY-1:0] upd_dly_reg;
  logic [OFS_DLY-1:0] ofs_dly_reg;
  wire logic [UPD_DLY-1:0] upd_dly_next;
  wire logic [OFS_DLY-1:0] ofs_dly_next;
  wire logic upd_active;
  wire logic ofs_active;

  // Register file
  logic [DATA_W-1:0] master_reg [REG_COUNT];
  logic [DATA_W-1:0] slave_reg [REG_COUNT];
  wire logic [FREQ_W-1:0] center_freq_word;
  wire logic [FREQ_W-1:0] offset_freq_word;
  wire logic [DATA_W-1:0] ctrl_byte;
  wire logic cf_en;
  wire logic fb_en;

  // Synthesis path
  logic [FREQ_W-1:0] freq_reg;
  logic [FREQ_W-1:0] acc_reg;
  logic [ROM_ADDR_W-1:0] phase_reg;
  logic [DAC_W-1:0] dac_code_reg;
  wire logic [FREQ_W-1:0] cf_term;
  wire logic [FREQ_W-1:0] of_term;
  wire logic [FREQ_W:0] freq_sum;
  wire logic [FREQ_W-1:0] freq_next;
  wire logic [FREQ_W-1:0] acc_fb;
  wire logic [FREQ_W:0] acc_sum;
  wire logic [FREQ_W-1:0] acc_next;
  wire logic [QUAD_W-1:0] quadrant;
  wire logic [ROM_ADDR_W-1:0] quad_offset;
  wire logic [ROM_ADDR_W:0] phase_sum;
  wire logic [ROM_ADDR_W-1:0] phase_next;
  wire logic signed [AMP_W-1:0] amp;
  wire logic [AMP_W:0] amp_rounded;
  wire logic round_ovf;
  wire logic [DAC_W-1:0] dac_next;

  // Strobe rising edge, captured only with enable low
  assign wr_edge = wr_s2_reg.strobe & ~wr_s3_reg
    & ~wr_s2_reg.write_en_n;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_s1_reg <= '0;
      wr_s2_reg <= '0;
      wr_s3_reg <= 1'b0;
    end
    else
    begin
      wr_s1_reg <= wr_port;
      wr_s2_reg <= wr_s1_reg;
      wr_s3_reg <= wr_s2_reg.strobe;
    end
  end

  // Two holding stages set the held-update latency
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_dly_reg <= 1'b0;
      wr_go_reg <= 1'b0;
      wr_sel_reg <= '0;
      wr_data_reg <= '0;
    end
    else
    begin
      wr_dly_reg <= wr_edge;
      wr_go_reg <= wr_dly_reg;
      wr_sel_reg <= wr_s2_reg.register_select_bus;
      wr_data_reg <= wr_s2_reg.write_data_bus;
    end
  end

  // Update and offset enable delay lines
  assign upd_dly_next = {upd_dly_reg[UPD_DLY-2:0], ~pins_s2_reg.update_n};
  assign ofs_dly_next = {ofs_dly_reg[OFS_DLY-2:0],
    pins_s2_reg.offset_word_enable};
  assign upd_active = upd_dly_reg[UPD_DLY-1];
  assign ofs_active = ofs_dly_reg[OFS_DLY-1];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      upd_dly_reg <= '0;
      ofs_dly_reg <= '0;
    end
    else
    begin
      pins_s1_reg <= ctrl_pins;
      pins_s2_reg <= pins_s1_reg;
      upd_dly_reg <= upd_dly_next;
      ofs_dly_reg <= ofs_dly_next;
    end
  end

  // Master and slave byte registers
  for (genvar i = 0; i < REG_COUNT; i++)
  begin : g_reg
    localparam logic [SEL_W-1:0] ADDR = (i == CTRL_IDX) ? CTRL_ADDR
      : SEL_W'(i);
    localparam logic [DATA_W-1:0] RST_VAL = (i == CTRL_IDX) ? CTRL_RESET
      : BYTE_RESET;
    wire logic hit;

    assign hit = wr_go_reg && (wr_sel_reg == ADDR);

    always_ff @(posedge core_clk)
    begin
      if (srst)
        master_reg[i] <= RST_VAL;
      else if (hit)
        master_reg[i] <= wr_data_reg;
    end

    always_ff @(posedge core_clk)
    begin
      if (srst)
        slave_reg[i] <= RST_VAL;
      else if (upd_active)
        slave_reg[i] <= master_reg[i];
    end

    if (i < WORD_BYTES)
    begin : g_cf
      assign center_freq_word[DATA_W*i +: DATA_W] = slave_reg[i];
    end
    else if (i < 2 * WORD_BYTES)
    begin : g_of
      assign offset_freq_word[DATA_W*(i-WORD_BYTES) +: DATA_W] =
        slave_reg[i];
    end
  end

  assign ctrl_byte = slave_reg[CTRL_IDX];
  assign cf_en = ctrl_byte[CTRL_CF_EN_BIT];
  assign fb_en = ctrl_byte[CTRL_ACC_FB_BIT];

  // Frequency word, carry above bit 47 dropped
  assign cf_term = cf_en ? center_freq_word : '0;
  assign of_term = ofs_active ? offset_freq_word : '0;
  assign freq_sum = {1'b0, cf_term} + {1'b0, of_term};
  assign freq_next = freq_sum[FREQ_W-1:0];

  // Phase accumulator, feedback gated by control bit
  assign acc_fb = fb_en ? acc_reg : '0;
  assign acc_sum = {1'b0, acc_fb} + {1'b0, freq_reg};
  assign acc_next = acc_sum[FREQ_W-1:0];

  // Quadrant offset on the table address
  assign quadrant = {pins_s2_reg.phase_sel_hi,
    pins_s2_reg.phase_sel_lo};
  assign quad_offset = {quadrant, {(ROM_ADDR_W-QUAD_W){1'b0}}};
  assign phase_sum = {1'b0, acc_reg[FREQ_W-1 -: ROM_ADDR_W]}
    + {1'b0, quad_offset};
  assign phase_next = phase_sum[ROM_ADDR_W-1:0];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      freq_reg <= '0;
      acc_reg <= '0;
      phase_reg <= '0;
    end
    else
    begin
      freq_reg <= freq_next;
      acc_reg <= acc_next;
      phase_reg <= phase_next;
    end
  end

  nfs_sine_rom u_rom
  (
    .core_clk(core_clk),
    .srst(srst),
    .phase_addr(phase_reg),
    .amp(amp)
  );

  // Round half up to 14 bits, saturate at positive peak
  assign amp_rounded = {amp[AMP_W-1], amp} + ROUND_HALF;
  assign round_ovf = ~amp[AMP_W-1] & amp_rounded[AMP_W-1];
  assign dac_next = round_ovf ? DAC_MAX
    : amp_rounded[AMP_W-1:ROUND_DROP];

  always_ff @(posedge core_clk)
  begin
    if (srst)
      dac_code_reg <= '0;
    else
      dac_code_reg <= dac_next;
  end

  assign dac_code = dac_code_reg;
  assign sine_amp = amp;

endmodule : nfs_core

`default_nettype wire

/* File: nfs_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module nfs_core_asserts
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Inputs
  input wire nfs_pkg::nfs_wr_port_t wr_port,
  input wire nfs_pkg::nfs_ctrl_pins_t ctrl_pins,
  // Outputs
  input wire logic [nfs_pkg::DAC_W-1:0] dac_code,
  input wire logic signed [nfs_pkg::AMP_W-1:0] sine_amp
);
  import nfs_pkg::*;
  logic signed [AMP_W:0] r_sum;
  logic signed [AMP_W-2:0] r_q;
  logic [DAC_W-1:0] r_code;
  assign r_sum = sine_amp + $signed(ROUND_HALF);
  assign r_q = r_sum[AMP_W:ROUND_DROP];
  assign r_code = (r_q[AMP_W-2:DAC_W-1] == 2'b01) ? DAC_MAX : r_q[DAC_W-1:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  round_val_a: assert property (1 |=> dac_code == $past(r_code))
    else $error("rounding");
  dac_track_a: assert property ($stable(sine_amp) |=> $stable(dac_code))
    else $error("dac moved");
  dac_sign_a: assert property (sine_amp > 0 |=> !dac_code[DAC_W-1])
    else $error("dac sign");
  dac_sat_a: assert property (sine_amp == AMP_PEAK |=> dac_code == DAC_MAX)
    else $error("saturation");
  zero_map_a: assert property (sine_amp == 0 |=> dac_code == 0)
    else $error("zero map");
  amp_range_a: assert property (sine_amp != 16'sh8000)
    else $error("amp range");
  reset_out_a: assert property ($fell(srst) |-> dac_code == 0 && sine_amp == 0)
    else $error("reset output");
  release_zero_a: assert property ($fell(srst) && !ctrl_pins.phase_sel_hi
    && !ctrl_pins.phase_sel_lo |-> (sine_amp == 0)[*4])
    else $error("release output");
endmodule : nfs_core_asserts
bind nfs_core nfs_core_asserts nfs_core_asserts_i (.core_clk(core_clk),
  .srst(srst), .wr_port(wr_port), .ctrl_pins(ctrl_pins),
  .dac_code(dac_code), .sine_amp(sine_amp));
`default_nettype wire

/* File: nfs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module nfs_host
(
  // Clock
  input wire logic core_clk,
  // Host pins
  output var nfs_pkg::nfs_wr_port_t wr_port,
  output var nfs_pkg::nfs_ctrl_pins_t ctrl_pins
);
  import nfs_pkg::*;
  int cyc = 0;
  int mark_cyc = 0;
  initial
  begin
    wr_port = '{1'b0, 1'b1, 4'h0, 8'h00};
    ctrl_pins = '{1'b1, 1'b0, 1'b0, 1'b0};
  end
  always @(posedge core_clk)
    cyc <= cyc + 1;
  // Pin levels change after an edge
  task set_pins(input logic [1:0] q, input logic ofs, input logic upd_n);
    @(negedge core_clk);
    ctrl_pins = '{upd_n, ofs, q[1], q[0]};
    mark_cyc = cyc;
  endtask : set_pins
  // One byte write, spaced from the last change
  task put_byte(input logic [3:0] a, input logic [7:0] d, input logic en_n);
    while (cyc < mark_cyc + UPDATE_LAT_CLKS + 1)
      @(negedge core_clk);
    @(negedge core_clk);
    wr_port = '{1'b0, en_n, a, d};
    @(negedge core_clk);
    wr_port.strobe = 1'b1;
    mark_cyc = cyc;
    repeat (2) @(negedge core_clk);
    wr_port.strobe = 1'b0;
    repeat (2) @(negedge core_clk);
    // Released bus shows the inverse
    wr_port = '{1'b0, 1'b1, a, ~d};
  endtask : put_byte
endmodule : nfs_host
`default_nettype wire

/* File: nfs_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nfs_core_tb;
  import nfs_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  nfs_wr_port_t wr_port;
  nfs_ctrl_pins_t ctrl_pins;
  logic [DAC_W-1:0] dac_code;
  logic signed [AMP_W-1:0] sine_amp;
  int err_total = 0;
  int comparisons = 0;
  int lat;
  logic [1:0] q;
  initial forever #2.5 core_clk = ~core_clk;
  nfs_host nfs_host_i (.core_clk(core_clk), .wr_port(wr_port),
    .ctrl_pins(ctrl_pins));
  nfs_core nfs_core_i (.core_clk(core_clk), .srst(srst), .wr_port(wr_port),
    .ctrl_pins(ctrl_pins), .dac_code(dac_code), .sine_amp(sine_amp));
  function automatic int quad_amp(input int k);
    case (k % 4)
      1: return 8191;
      3: return -8191;
      default: return 0;
    endcase
  endfunction : quad_amp
  task chk_code(input string n, input logic [DAC_W-1:0] e,
    input logic [DAC_W-1:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk_code
  task chk_near(input string n, input int e, input logic [DAC_W-1:0] g);
    comparisons++;
    if ((($signed(g) - e) inside {[-16:16]}) !== 1'b1)
    begin
      err_total++;
      $display("[ERR] %s exp %0d got %0d", n, e, $signed(g));
    end
  endtask : chk_near
  task chk_lat(input string n, input int e, input int g);
    comparisons++;
    if (g != e)
    begin
      err_total++;
      $display("[ERR] %s exp %0d got %0d", n, e, g);
    end
  endtask : chk_lat
  // Clocks from the last strobe rise or pin change to a nonzero output
  task wait_nz();
    int n;
    n = 0;
    while (dac_code === '0 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    lat = nfs_host_i.cyc - nfs_host_i.mark_cyc;
  endtask : wait_nz
  task results();
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // Whole sequence needs about 340 clocks
  initial
  begin
    #20us;
    err_total++;
    results();
  end
  initial
  begin
    lat = $urandom(51);
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_code("reset", '0, dac_code);
    nfs_host_i.set_pins(2'h0, 1'b0, 1'b0);
    nfs_host_i.put_byte(4'h5, 8'h40, 1'b1);
    repeat (20) @(negedge core_clk);
    chk_code("refused", '0, dac_code);
    nfs_host_i.put_byte(4'h5, 8'h40, 1'b0);
    wait_nz();
    chk_lat("held lat", WRITE_LAT_CLKS, lat);
    for (int k = 1; k < 9; k++)
    begin
      chk_near("turn", quad_amp(k), dac_code);
      @(negedge core_clk);
    end
    nfs_host_i.put_byte(CTRL_ADDR, 8'h00, 1'b0);
    repeat (16) @(negedge core_clk);
    chk_code("no center", '0, dac_code);
    for (int i = 0; i < 12; i++)
    begin
      q = (i < 4) ? 2'(i) : 2'($urandom_range(3));
      nfs_host_i.set_pins(q, 1'b0, 1'b0);
      repeat (5) @(negedge core_clk);
      chk_near("quadrant", quad_amp(q), dac_code);
    end
    nfs_host_i.set_pins(2'h0, 1'b0, 1'b1);
    nfs_host_i.put_byte(CTRL_ADDR, CTRL_RESET, 1'b0);
    for (int a = 2; a < 6; a++)
      nfs_host_i.put_byte(4'(a), (a == 5) ? 8'h40 : 8'h00, 1'b0);
    repeat (20) @(negedge core_clk);
    chk_code("master only", '0, dac_code);
    nfs_host_i.set_pins(2'h0, 1'b0, 1'b0);
    wait_nz();
    chk_lat("update lat", UPDATE_LAT_CLKS, lat);
    nfs_host_i.put_byte(CTRL_ADDR, 8'h10, 1'b0);
    nfs_host_i.put_byte(4'hb, 8'hc0, 1'b0);
    repeat (14) @(negedge core_clk);
    chk_near("no feedback", 8191, dac_code);
    nfs_host_i.set_pins(2'h0, 1'b1, 1'b0);
    repeat (13) @(negedge core_clk);
    chk_near("offset early", 8191, dac_code);
    @(negedge core_clk);
    chk_code("offset sum", '0, dac_code);
    results();
  end
endmodule : nfs_core_tb
`default_nettype wire
